// *** ctxo_core.sv ***
// Execution unit for transfer, exchange, word test and wait instructions
`timescale 1ns/1ps
module ctxo_core
   import ctxo_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        issue_valid,
   input  wire logic [15:0] issue_opcode,
   input  wire logic [15:0] mem_word,
   input  wire logic        irq_pending,
   input  wire logic        flag_result_we,
   input  wire logic [11:0] flag_result,
   input  wire logic        flag_pull_all,
   input  wire logic        flag_pull_pcx,
   input  wire logic [15:0] flag_pulled,
   input  wire logic        branch_valid,
   input  wire logic        branch_taken,
   input  wire logic [3:0]  branch_cyc_taken,
   input  wire logic [3:0]  branch_cyc_not_taken,
   output logic             issue_ready,
   output logic             busy,
   output logic             waiting,
   output logic             illegal,
   output ctxo_regs_s       regs
);
   // ------------------------------------------------------------
   // Decode and helpers
   // ------------------------------------------------------------
   ctxo_dec_s dec;

   ctxo_decode u_decode (
      .opcode (issue_opcode),
      .dec    (dec)
   );

   function automatic logic [19:0] idx_full(input ctxo_regs_s r, input logic [1:0] sel);
      case (sel)
         IDX_Y:   idx_full = {r.bank_y, r.ptr_y};
         IDX_Z:   idx_full = {r.bank_z, r.ptr_z};
         default: idx_full = {r.bank_x, r.ptr_x};
      endcase
   endfunction

   typedef enum logic [1:0] {CTXO_IDLE, CTXO_EXEC, CTXO_SLEEP} ctxo_state_e;

   ctxo_state_e state;
   ctxo_state_e next_state;
   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   ctxo_regs_s  next_regs;
   logic        next_illegal;
   logic [19:0] src_val;
   logic [19:0] sp_val;

   assign issue_ready = (state == CTXO_IDLE);
   assign busy        = (state != CTXO_IDLE);
   assign waiting     = (state == CTXO_SLEEP);
   assign src_val     = idx_full(regs, dec.src);
   assign sp_val      = {regs.bank_s, regs.sp};

   // ------------------------------------------------------------
   // Next state and register values
   // ------------------------------------------------------------
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_regs    = regs;
      next_illegal = 1'b0;
      case (state)
         CTXO_IDLE: begin
            if (issue_valid) begin
               next_cnt   = dec.cycles - 4'h1;
               next_state = CTXO_EXEC;
               case (dec.op)
                  CTXO_WTEST: begin
                     next_regs.flags[FLAG_N_BIT] = mem_word[15];
                     next_regs.flags[FLAG_Z_BIT] = (mem_word == RST_WORD);
                     next_regs.flags[FLAG_V_BIT] = 1'b0;
                     next_regs.flags[FLAG_C_BIT] = 1'b0;
                  end
                  CTXO_SP_TO_IDX: begin
                     case (dec.dst)
                        IDX_Y:   {next_regs.bank_y, next_regs.ptr_y} = sp_val + SP_ADJUST;
                        IDX_Z:   {next_regs.bank_z, next_regs.ptr_z} = sp_val + SP_ADJUST;
                        default: {next_regs.bank_x, next_regs.ptr_x} = sp_val + SP_ADJUST;
                     endcase
                  end
                  CTXO_IDX_TO_SP: begin
                     {next_regs.bank_s, next_regs.sp} = src_val - SP_ADJUST;
                  end
                  CTXO_IDX_TO_IDX: begin
                     case (dec.dst)
                        IDX_Y:   {next_regs.bank_y, next_regs.ptr_y} = src_val;
                        IDX_Z:   {next_regs.bank_z, next_regs.ptr_z} = src_val;
                        default: {next_regs.bank_x, next_regs.ptr_x} = src_val;
                     endcase
                  end
                  CTXO_BANK_TO_B: begin
                     next_regs.d[7:0] = {4'h0, src_val[19:16]};
                  end
                  CTXO_WAIT: begin
                     next_state = CTXO_SLEEP;
                  end
                  CTXO_SWAP_AB: begin
                     next_regs.d = {regs.d[7:0], regs.d[15:8]};
                  end
                  CTXO_SWAP_DE: begin
                     next_regs.d = regs.e;
                     next_regs.e = regs.d;
                  end
                  CTXO_SWAP_D_IDX, CTXO_SWAP_E_IDX: begin
                     if (dec.op == CTXO_SWAP_D_IDX) begin
                        next_regs.d = src_val[15:0];
                     end else begin
                        next_regs.e = src_val[15:0];
                     end
                     case (dec.dst)
                        IDX_Y:   next_regs.ptr_y = (dec.op == CTXO_SWAP_D_IDX) ? regs.d : regs.e;
                        IDX_Z:   next_regs.ptr_z = (dec.op == CTXO_SWAP_D_IDX) ? regs.d : regs.e;
                        default: next_regs.ptr_x = (dec.op == CTXO_SWAP_D_IDX) ? regs.d : regs.e;
                     endcase
                  end
                  default: begin
                     next_illegal = 1'b1;
                     next_state   = CTXO_IDLE;
                  end
               endcase
            end else if (branch_valid) begin
               next_cnt = (branch_taken ? branch_cyc_taken : branch_cyc_not_taken) - 4'h1;
               // A one-cycle branch ends in this cycle
               if (next_cnt != 4'h0) begin
                  next_state = CTXO_EXEC;
               end
            end
         end
         CTXO_EXEC: begin
            if (cnt <= 4'h1) begin
               next_state = CTXO_IDLE;
            end
            next_cnt = cnt - 4'h1;
         end
         CTXO_SLEEP: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (irq_pending) begin
               next_cnt   = 4'h0;
               next_state = CTXO_IDLE;
            end
         end
         default: next_state = CTXO_IDLE;
      endcase
      // Flag paths from the rest of the core
      if (flag_pull_all) begin
         next_regs.flags = flag_pulled;
      end else if (flag_pull_pcx) begin
         next_regs.flags[3:0] = flag_pulled[3:0];
      end else if (flag_result_we) begin
         next_regs.flags[15:4] = flag_result;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state   <= CTXO_IDLE;
         cnt     <= 4'h0;
         illegal <= 1'b0;
         regs    <= '{RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD,
                      RST_BANK, RST_BANK, RST_BANK, RST_BANK, RST_WORD};
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         illegal <= next_illegal;
         regs    <= next_regs;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_wtest_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_WTEST && !flag_pull_all && !flag_pull_pcx
      && !flag_result_we |=> regs.flags[FLAG_V_BIT] == 1'b0 && regs.flags[FLAG_C_BIT] == 1'b0
      && regs.flags[FLAG_N_BIT] == $past(mem_word[15])
      && regs.flags[FLAG_Z_BIT] == ($past(mem_word) == 16'h0000))
      else $error("word test flags wrong");
   a_wtest_length: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_WTEST |=> busy [*5] ##1 issue_ready)
      else $error("word test not six cycles");
   a_sp_to_idx: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_SP_TO_IDX && dec.dst == IDX_X
      |=> {regs.bank_x, regs.ptr_x} == $past(sp_val) + 20'h00002)
      else $error("stack to index copy wrong");
   a_idx_to_sp: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_IDX_TO_SP
      |=> {regs.bank_s, regs.sp} == $past(src_val) - 20'h00002)
      else $error("index to stack copy wrong");
   a_xfer_length: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_IDX_TO_IDX |=> busy ##1 issue_ready)
      else $error("transfer not two cycles");
   a_bank_to_b: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_BANK_TO_B
      |=> regs.d[7:4] == 4'h0 && regs.d[3:0] == $past(src_val[19:16]))
      else $error("extension to B wrong");
   a_wait_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      waiting && !irq_pending |=> waiting)
      else $error("wait left without interrupt");
   a_swap_de: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_SWAP_DE
      |=> regs.d == $past(regs.e) && regs.e == $past(regs.d))
      else $error("D E swap wrong");
   a_swap_bank_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op == CTXO_SWAP_D_IDX
      |=> $stable(regs.bank_x) && $stable(regs.bank_y) && $stable(regs.bank_z))
      else $error("swap touched extension");
   a_flags_kept: assert property (@(posedge clk_sys) disable iff (!arst_n)
      issue_ready && issue_valid && dec.op != CTXO_WTEST && !flag_pull_all && !flag_pull_pcx
      && !flag_result_we |=> $stable(regs.flags))
      else $error("transfer changed flags");
   a_pcx_kept: assert property (@(posedge clk_sys) disable iff (!arst_n)
      flag_result_we && !flag_pull_all && !flag_pull_pcx
      |=> regs.flags[3:0] == $past(regs.flags[3:0]))
      else $error("result update touched PC extension");
endmodule

// *** ctxo_decode.sv ***
// Opcode decoder for the transfer, exchange, test and wait group
`timescale 1ns/1ps
module ctxo_decode
   import ctxo_pkg::*;
(
   input  wire logic [15:0] opcode,
   output ctxo_dec_s        dec
);
   always_comb begin
      dec = '{op: CTXO_NONE, src: IDX_X, dst: IDX_X, cycles: CYC_XFER};
      case (opcode)
         OP_WTEST_X, OP_WTEST_Y, OP_WTEST_Z, OP_WTEST_E: begin
            dec.op     = CTXO_WTEST;
            dec.cycles = CYC_WTEST;
         end
         OP_SP_TO_X: begin dec.op = CTXO_SP_TO_IDX; dec.dst = IDX_X; end
         OP_SP_TO_Y: begin dec.op = CTXO_SP_TO_IDX; dec.dst = IDX_Y; end
         OP_SP_TO_Z: begin dec.op = CTXO_SP_TO_IDX; dec.dst = IDX_Z; end
         OP_X_TO_SP: begin dec.op = CTXO_IDX_TO_SP; dec.src = IDX_X; end
         OP_Y_TO_SP: begin dec.op = CTXO_IDX_TO_SP; dec.src = IDX_Y; end
         OP_Z_TO_SP: begin dec.op = CTXO_IDX_TO_SP; dec.src = IDX_Z; end
         OP_X_TO_Y: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_X; dec.dst = IDX_Y; end
         OP_X_TO_Z: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_X; dec.dst = IDX_Z; end
         OP_Y_TO_X: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_Y; dec.dst = IDX_X; end
         OP_Y_TO_Z: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_Y; dec.dst = IDX_Z; end
         OP_Z_TO_X: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_Z; dec.dst = IDX_X; end
         OP_Z_TO_Y: begin dec.op = CTXO_IDX_TO_IDX; dec.src = IDX_Z; dec.dst = IDX_Y; end
         OP_BKX_TO_B: begin dec.op = CTXO_BANK_TO_B; dec.src = IDX_X; end
         OP_BKY_TO_B: begin dec.op = CTXO_BANK_TO_B; dec.src = IDX_Y; end
         OP_BKZ_TO_B: begin dec.op = CTXO_BANK_TO_B; dec.src = IDX_Z; end
         OP_WAIT: begin
            dec.op     = CTXO_WAIT;
            dec.cycles = CYC_WAIT;
         end
         OP_SWAP_AB: dec.op = CTXO_SWAP_AB;
         OP_SWAP_DE: dec.op = CTXO_SWAP_DE;
         OP_SWAP_DX: begin dec.op = CTXO_SWAP_D_IDX; dec.src = IDX_X; dec.dst = IDX_X; end
         OP_SWAP_DY: begin dec.op = CTXO_SWAP_D_IDX; dec.src = IDX_Y; dec.dst = IDX_Y; end
         OP_SWAP_DZ: begin dec.op = CTXO_SWAP_D_IDX; dec.src = IDX_Z; dec.dst = IDX_Z; end
         OP_SWAP_EX: begin dec.op = CTXO_SWAP_E_IDX; dec.src = IDX_X; dec.dst = IDX_X; end
         OP_SWAP_EY: begin dec.op = CTXO_SWAP_E_IDX; dec.src = IDX_Y; dec.dst = IDX_Y; end
         OP_SWAP_EZ: begin dec.op = CTXO_SWAP_E_IDX; dec.src = IDX_Z; dec.dst = IDX_Z; end
         default: dec.op = CTXO_NONE;
      endcase
   end
endmodule

// *** ctxo_pkg.sv ***
// Package of opcodes, widths, timing and carriers for the transfer/exchange/test decoder
// Function
// - Word test subtracts zero, sets N and Z, clears V and C, 6 cycles.
// - Stack copy to X, Y or Z loads extension and pointer plus 2, 2 cycles.
// - X, Y or Z copy to stack loads extension and index minus 2, 2 cycles.
// - Index-to-index copies move full 20-bit value unchanged, 2 cycles.
// - Extension-to-B writes 4-bit extension to B low, clears B high, 2 cycles.
// - Wait-for-interrupt suspends execution until interrupt; listed cost 8 cycles.
// - Swap A with B, or D with E, in 2 cycles.
// - Swap D with X, Y or Z 16-bit values, extensions untouched, 2 cycles.
// - Swap E with X, Y or Z 16-bit values, extensions untouched, 2 cycles.
// - Result-updated flags change bits 15 to 4; PC extension kept.
// - Whole-register restore from stack loads all 16 bits.
// - PC extension restore from stack changes only that field.
// - Conditional branch takes first count when taken, second when not.
package ctxo_pkg;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [15:0] OP_WTEST_X  = 16'h2706;
   localparam logic [15:0] OP_WTEST_Y  = 16'h2716;
   localparam logic [15:0] OP_WTEST_Z  = 16'h2726;
   localparam logic [15:0] OP_WTEST_E  = 16'h2736;
   localparam logic [15:0] OP_SP_TO_X  = 16'h274f;
   localparam logic [15:0] OP_SP_TO_Y  = 16'h275f;
   localparam logic [15:0] OP_SP_TO_Z  = 16'h276f;
   localparam logic [15:0] OP_X_TO_SP  = 16'h374e;
   localparam logic [15:0] OP_Y_TO_SP  = 16'h375e;
   localparam logic [15:0] OP_Z_TO_SP  = 16'h376e;
   localparam logic [15:0] OP_X_TO_Y   = 16'h275c;
   localparam logic [15:0] OP_X_TO_Z   = 16'h276c;
   localparam logic [15:0] OP_Y_TO_X   = 16'h274d;
   localparam logic [15:0] OP_Y_TO_Z   = 16'h276d;
   localparam logic [15:0] OP_Z_TO_X   = 16'h274e;
   localparam logic [15:0] OP_Z_TO_Y   = 16'h275e;
   localparam logic [15:0] OP_BKX_TO_B = 16'h37ac;
   localparam logic [15:0] OP_BKY_TO_B = 16'h37ad;
   localparam logic [15:0] OP_BKZ_TO_B = 16'h37ae;
   localparam logic [15:0] OP_WAIT     = 16'h27f3;
   localparam logic [15:0] OP_SWAP_AB  = 16'h371a;
   localparam logic [15:0] OP_SWAP_DE  = 16'h277a;
   localparam logic [15:0] OP_SWAP_DX  = 16'h37cc;
   localparam logic [15:0] OP_SWAP_DY  = 16'h37dc;
   localparam logic [15:0] OP_SWAP_DZ  = 16'h37ec;
   localparam logic [15:0] OP_SWAP_EX  = 16'h374c;
   localparam logic [15:0] OP_SWAP_EY  = 16'h375c;
   localparam logic [15:0] OP_SWAP_EZ  = 16'h376c;
   // ------------------------------------------------------------
   // Cycle counts and constants
   // ------------------------------------------------------------
   localparam logic [3:0]  CYC_WTEST    = 4'h6;
   localparam logic [3:0]  CYC_XFER     = 4'h2;
   localparam logic [3:0]  CYC_WAIT     = 4'h8;
   localparam logic [19:0] SP_ADJUST    = 20'h00002;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [3:0]  RST_BANK     = 4'h0;
   localparam logic [3:0]  FLAG_PCX_LSB = 4'h0;
   localparam int          FLAG_N_BIT   = 11;
   localparam int          FLAG_Z_BIT   = 10;
   localparam int          FLAG_V_BIT   = 9;
   localparam int          FLAG_C_BIT   = 8;
   localparam logic [1:0]  IDX_X        = 2'h0;
   localparam logic [1:0]  IDX_Y        = 2'h1;
   localparam logic [1:0]  IDX_Z        = 2'h2;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CTXO_NONE, CTXO_WTEST, CTXO_SP_TO_IDX, CTXO_IDX_TO_SP, CTXO_IDX_TO_IDX,
      CTXO_BANK_TO_B, CTXO_WAIT, CTXO_SWAP_AB, CTXO_SWAP_DE, CTXO_SWAP_D_IDX,
      CTXO_SWAP_E_IDX
   } ctxo_op_e;

   typedef struct packed {
      ctxo_op_e   op;
      logic [1:0] src;
      logic [1:0] dst;
      logic [3:0] cycles;
   } ctxo_dec_s;

   typedef struct packed {
      logic [15:0] d;
      logic [15:0] e;
      logic [15:0] ptr_x;
      logic [15:0] ptr_y;
      logic [15:0] ptr_z;
      logic [15:0] sp;
      logic [3:0]  bank_x;
      logic [3:0]  bank_y;
      logic [3:0]  bank_z;
      logic [3:0]  bank_s;
      logic [15:0] flags;
   } ctxo_regs_s;
endpackage

// *** tb.sv ***
// Self-checking testbench for the transfer, exchange, word test and wait unit
`timescale 1ns/1ps
module tb
   import ctxo_pkg::*;
;
   localparam int          W         = $bits(ctxo_regs_s);
   localparam logic [15:0] SEQ [28]  = '{
      OP_SP_TO_X, OP_SWAP_DX, OP_SWAP_AB, OP_SWAP_DY, OP_Y_TO_SP, OP_SP_TO_Z, OP_X_TO_SP,
      OP_SP_TO_X, OP_SWAP_EZ, OP_SWAP_DE, OP_SWAP_AB, OP_SWAP_DZ, OP_Z_TO_Y, OP_SWAP_EY,
      OP_SWAP_EX, OP_X_TO_Y, OP_SWAP_DY, OP_Y_TO_X, OP_Z_TO_X, OP_Y_TO_Z, OP_X_TO_Z,
      OP_Z_TO_SP, OP_SP_TO_Y, OP_BKX_TO_B, OP_SWAP_DY, OP_BKY_TO_B, OP_SWAP_DZ, OP_BKZ_TO_B};
   localparam logic [15:0] TW_OP [4] = '{OP_WTEST_X, OP_WTEST_Y, OP_WTEST_Z, OP_WTEST_E};
   localparam logic [15:0] TW_MW [4] = '{16'h8000, 16'h0000, 16'h7fff, 16'h0001};

   logic        clk_sys, arst_n, issue_valid, irq_pending, flag_result_we, flag_pull_all;
   logic        flag_pull_pcx, branch_valid, branch_taken, issue_ready, busy, waiting, illegal;
   logic [15:0] issue_opcode, mem_word, flag_pulled;
   logic [11:0] flag_result;
   logic [3:0]  branch_cyc_taken, branch_cyc_not_taken;
   ctxo_regs_s  regs, m;
   int          errors, checked, n;

   ctxo_core dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .issue_valid(issue_valid),
      .issue_opcode(issue_opcode), .mem_word(mem_word), .irq_pending(irq_pending),
      .flag_result_we(flag_result_we), .flag_result(flag_result),
      .flag_pull_all(flag_pull_all), .flag_pull_pcx(flag_pull_pcx),
      .flag_pulled(flag_pulled), .branch_valid(branch_valid),
      .branch_taken(branch_taken), .branch_cyc_taken(branch_cyc_taken),
      .branch_cyc_not_taken(branch_cyc_not_taken), .issue_ready(issue_ready), .busy(busy),
      .waiting(waiting), .illegal(illegal), .regs(regs));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Offer one request, then count cycles until the unit is ready again
   task automatic run(input logic br, input logic [15:0] op, input logic [15:0] mw);
      issue_valid  = !br;
      branch_valid = br;
      issue_opcode = op;
      mem_word     = mw;
      tick();
      issue_valid  = 1'b0;
      branch_valid = 1'b0;
      mem_word     = ~mw;
      n = 1;
      while (issue_ready !== 1'b1) begin
         if (n > 200) begin
            errors++;
            final_report();
         end
         tick();
         n++;
      end
   endtask

   task automatic flag_port(input logic [2:0] sel, input logic [15:0] v);
      {flag_pull_all, flag_pull_pcx, flag_result_we} = sel;
      flag_pulled = v;
      flag_result = ~v[15:4];
      tick();
      {flag_pull_all, flag_pull_pcx, flag_result_we} = 3'h0;
   endtask

   task automatic model(input logic [15:0] op);
      case (op)
         OP_SP_TO_X: {m.bank_x, m.ptr_x} = {m.bank_s, m.sp} + 20'h00002;
         OP_SP_TO_Y: {m.bank_y, m.ptr_y} = {m.bank_s, m.sp} + 20'h00002;
         OP_SP_TO_Z: {m.bank_z, m.ptr_z} = {m.bank_s, m.sp} + 20'h00002;
         OP_X_TO_SP: {m.bank_s, m.sp} = {m.bank_x, m.ptr_x} - 20'h00002;
         OP_Y_TO_SP: {m.bank_s, m.sp} = {m.bank_y, m.ptr_y} - 20'h00002;
         OP_Z_TO_SP: {m.bank_s, m.sp} = {m.bank_z, m.ptr_z} - 20'h00002;
         OP_X_TO_Y:  {m.bank_y, m.ptr_y} = {m.bank_x, m.ptr_x};
         OP_X_TO_Z:  {m.bank_z, m.ptr_z} = {m.bank_x, m.ptr_x};
         OP_Y_TO_X:  {m.bank_x, m.ptr_x} = {m.bank_y, m.ptr_y};
         OP_Y_TO_Z:  {m.bank_z, m.ptr_z} = {m.bank_y, m.ptr_y};
         OP_Z_TO_X:  {m.bank_x, m.ptr_x} = {m.bank_z, m.ptr_z};
         OP_Z_TO_Y:  {m.bank_y, m.ptr_y} = {m.bank_z, m.ptr_z};
         OP_BKX_TO_B: m.d[7:0] = {4'h0, m.bank_x};
         OP_BKY_TO_B: m.d[7:0] = {4'h0, m.bank_y};
         OP_BKZ_TO_B: m.d[7:0] = {4'h0, m.bank_z};
         OP_SWAP_AB: m.d = {m.d[7:0], m.d[15:8]};
         OP_SWAP_DE: {m.d, m.e} = {m.e, m.d};
         OP_SWAP_DX: {m.d, m.ptr_x} = {m.ptr_x, m.d};
         OP_SWAP_DY: {m.d, m.ptr_y} = {m.ptr_y, m.d};
         OP_SWAP_DZ: {m.d, m.ptr_z} = {m.ptr_z, m.d};
         OP_SWAP_EX: {m.e, m.ptr_x} = {m.ptr_x, m.e};
         OP_SWAP_EY: {m.e, m.ptr_y} = {m.ptr_y, m.e};
         OP_SWAP_EZ: {m.e, m.ptr_z} = {m.ptr_z, m.e};
         default: ;
      endcase
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_flag_ports();
      flag_port(3'h4, 16'ha5c3);
      m.flags = 16'ha5c3;
      chk(regs, m, "flags pull all");
      flag_port(3'h2, 16'h0ff6);
      m.flags[3:0] = 4'h6;
      chk(regs, m, "flags pull pc extension");
      flag_port(3'h1, 16'h3c90);
      m.flags[15:4] = 12'hc36;
      chk(regs, m, "flags result");
      flag_port(3'h7, 16'h5a5a);
      m.flags = 16'h5a5a;
      chk(regs, m, "flags priority");
   endtask

   task automatic sc_word_test();
      for (int i = 0; i < 4; i++) begin
         flag_port(3'h4, 16'hf3fa);
         m.flags = 16'hf3fa;
         run(1'b0, TW_OP[i], TW_MW[i]);
         m.flags[11:8] = {TW_MW[i][15], TW_MW[i] == 16'h0000, 2'b00};
         chk(W'(n), W'(6), "word test cycles");
         chk(regs, m, "word test flags");
      end
   endtask

   task automatic sc_transfers();
      flag_port(3'h4, 16'h7e5d);
      m.flags = 16'h7e5d;
      for (int i = 0; i < 28; i++) begin
         run(1'b0, SEQ[i], 16'hffff);
         model(SEQ[i]);
         chk(W'(n), W'(2), "transfer cycles");
         chk(regs, m, "transfer result");
      end
   endtask

   task automatic sc_wait();
      irq_pending = 1'b1;
      run(1'b0, OP_WAIT, 16'h0000);
      chk(W'(n), W'(8), "wait listed cost");
      irq_pending  = 1'b0;
      issue_valid  = 1'b1;
      issue_opcode = OP_WAIT;
      tick();
      issue_valid = 1'b0;
      repeat (12) tick();
      chk(W'({busy, waiting, issue_ready}), W'(3'b110), "wait sleeping");
      irq_pending = 1'b1;
      tick();
      irq_pending = 1'b0;
      chk(W'({busy, issue_ready}), W'(2'b01), "wait woken");
      chk(regs, m, "wait keeps state");
   endtask

   task automatic sc_branch();
      branch_cyc_taken     = 4'hf;
      branch_cyc_not_taken = 4'h1;
      for (int t = 0; t < 2; t++) begin
         branch_taken = (t == 0);
         run(1'b1, 16'h0000, 16'h0000);
         chk(W'(n), W'((t == 0) ? 15 : 1), "branch cycles");
      end
   endtask

   task automatic sc_illegal();
      run(1'b0, 16'h3706, 16'h0000);
      chk(W'({illegal, busy}), W'(2'b10), "unknown opcode flagged");
      tick();
      chk(W'(illegal), W'(1'b0), "flag lasts one cycle");
      chk(regs, m, "unknown opcode ignored");
   endtask

   initial begin
      {arst_n, issue_valid, irq_pending, flag_result_we, flag_pull_all} = 5'h00;
      {flag_pull_pcx, branch_valid, branch_taken} = 3'h0;
      {issue_opcode, mem_word, flag_pulled} = 48'h0;
      flag_result = 12'h000;
      {branch_cyc_taken, branch_cyc_not_taken} = 8'h11;
      errors  = 0;
      checked = 0;
      m = '0;
      repeat (2) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      chk(regs, m, "reset value");
      chk(W'({issue_ready, busy, waiting, illegal}), W'(4'b1000), "reset state");
      sc_flag_ports();
      sc_word_test();
      sc_transfers();
      sc_wait();
      sc_branch();
      sc_illegal();
      final_report();
   end
endmodule
